// ==== rtl/domain_reset_release.sv ====
// Reset-release sequencer for one power domain, with an APB register port.
// Assumes the hold acknowledge arrives asynchronously from the domain and the
// power-up request is a one-cycle pulse on the controller clock.
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps

// How it works
// - On each power-up the domain reset is asserted and held until the domain raises its hold acknowledge.
// - After the acknowledge, reset is extended by a down-counter loaded from bits 9:0 of the reset-width register.
// - The reset-width field gives its value plus one cycles, so 0x000 is one cycle and 0x3ff is 1024.
// - When the reset-width count ends, a second counter is loaded from the release-length field.
// - The release-length field is bits 9:0 with the same value-plus-one encoding, 1 to 1024 cycles.
// - When the second counter reaches zero the active-low domain reset is released.
// - A third counter is loaded from the same release-length field and counts only after the second is at zero.
// - When the third counter reaches zero the domain-ready output is raised.
module domain_reset_release (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [3:0] I_PSTRB,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_POWER_UP,
  input wire logic I_RESET_HOLD_ACK,
  output logic O_DOMAIN_RESET_N,
  output logic O_DOMAIN_READY
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  localparam int CW = domain_reset_pkg::COUNT_FIELD_W;
  localparam int LSB = domain_reset_pkg::COUNT_FIELD_LSB;

  if (CW < 9 || CW > 16) begin : g_width_check
    $error("domain_reset_release needs a count field of 9 to 16 bits");
  end

  domain_reset_pkg::seq_state_t state_reg;
  domain_reset_pkg::seq_state_t state_next;
  domain_reset_pkg::seq_status_t status;
  domain_reset_pkg::apb_req_t req;
  logic [CW-1:0] reset_width_reg;
  logic [CW-1:0] release_length_reg;
  logic ack_meta_reg;
  logic ack_sync_reg;
  logic start;
  logic ctrl_start;
  logic bus_write;
  logic setup_phase;
  logic mapped;
  logic [31:0] read_value;
  logic [CW-1:0] ext_count;
  logic [CW-1:0] core_count;
  logic [CW-1:0] ready_count;
  logic ext_zero;
  logic core_zero;
  logic ready_zero;
  logic ext_load;
  logic core_load;
  logic ready_load;

  // ==========================================================================
  // APB slave
  // ==========================================================================
  assign req = '{addr: I_PADDR, write: I_PWRITE, strb: I_PSTRB, wdata: I_PWDATA};
  assign setup_phase = I_PSEL && !I_PENABLE;
  // A write lands only at the edge where the access phase sees pready high.
  assign bus_write = I_PSEL && I_PENABLE && O_PREADY && req.write;
  assign mapped = (req.addr == domain_reset_pkg::RESET_WIDTH_OFFSET) ||
                  (req.addr == domain_reset_pkg::RELEASE_LENGTH_OFFSET) ||
                  (req.addr == domain_reset_pkg::SEQ_STATUS_OFFSET) ||
                  (req.addr == domain_reset_pkg::SEQ_CONTROL_OFFSET);
  assign ctrl_start = bus_write && (req.addr == domain_reset_pkg::SEQ_CONTROL_OFFSET) &&
                      req.strb[0] && req.wdata[domain_reset_pkg::CONTROL_START_BIT];

  always_comb begin
    status = '0;
    status.ready = O_DOMAIN_READY;
    status.reset_n = O_DOMAIN_RESET_N;
    status.hold_ack = ack_sync_reg;
    status.state = state_reg;
    case (state_reg)
      domain_reset_pkg::SEQ_EXTEND: status.count = ext_count;
      domain_reset_pkg::SEQ_RELEASE: status.count = core_count;
      domain_reset_pkg::SEQ_READY_WAIT: status.count = ready_count;
      default: status.count = '0;
    endcase
  end

  always_comb begin
    read_value = 32'h0000_0000;
    case (req.addr)
      domain_reset_pkg::RESET_WIDTH_OFFSET: read_value[LSB +: CW] = reset_width_reg;
      domain_reset_pkg::RELEASE_LENGTH_OFFSET: read_value[LSB +: CW] = release_length_reg;
      domain_reset_pkg::SEQ_STATUS_OFFSET: read_value = status;
      default: read_value = 32'h0000_0000;
    endcase
  end

  // Answer is prepared in the setup cycle so every bus output is a flop and
  // the access phase completes in one cycle.
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
    end else begin
      O_PREADY <= setup_phase;
      O_PSLVERR <= setup_phase && !mapped;
      O_PRDATA <= (setup_phase && !req.write) ? read_value : 32'h0000_0000;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      reset_width_reg <= domain_reset_pkg::RESET_WIDTH_RESET;
    end else if (bus_write && (req.addr == domain_reset_pkg::RESET_WIDTH_OFFSET)) begin
      if (req.strb[0]) begin
        reset_width_reg[7:0] <= req.wdata[LSB +: 8];
      end
      if (req.strb[1]) begin
        reset_width_reg[CW-1:8] <= req.wdata[LSB+8 +: CW-8];
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      release_length_reg <= domain_reset_pkg::RELEASE_LENGTH_RESET;
    end else if (bus_write && (req.addr == domain_reset_pkg::RELEASE_LENGTH_OFFSET)) begin
      if (req.strb[0]) begin
        release_length_reg[7:0] <= req.wdata[LSB +: 8];
      end
      if (req.strb[1]) begin
        release_length_reg[CW-1:8] <= req.wdata[LSB+8 +: CW-8];
      end
    end
  end

  // ==========================================================================
  // Acknowledge synchroniser
  // ==========================================================================
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
    end else begin
      ack_meta_reg <= I_RESET_HOLD_ACK;
      ack_sync_reg <= ack_meta_reg;
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // A new request restarts the sequence from any state.
  assign start = I_POWER_UP || ctrl_start;
  // counters capture the field only at their load
  assign ext_load = (state_reg == domain_reset_pkg::SEQ_HOLD) && ack_sync_reg && !start;
  assign core_load = (state_reg == domain_reset_pkg::SEQ_EXTEND) && ext_zero && !start;
  assign ready_load = (state_reg == domain_reset_pkg::SEQ_RELEASE) && core_zero && !start;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      domain_reset_pkg::SEQ_HOLD: if (ack_sync_reg) state_next = domain_reset_pkg::SEQ_EXTEND;
      domain_reset_pkg::SEQ_EXTEND: if (ext_zero) state_next = domain_reset_pkg::SEQ_RELEASE;
      domain_reset_pkg::SEQ_RELEASE: if (core_zero) state_next = domain_reset_pkg::SEQ_READY_WAIT;
      domain_reset_pkg::SEQ_READY_WAIT: if (ready_zero) state_next = domain_reset_pkg::SEQ_RUN;
      domain_reset_pkg::SEQ_IDLE,
      domain_reset_pkg::SEQ_RUN: state_next = state_reg;
      default: state_next = domain_reset_pkg::SEQ_IDLE;
    endcase
    if (start) begin
      state_next = domain_reset_pkg::SEQ_HOLD;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_reg <= domain_reset_pkg::SEQ_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  delay_down_counter #(.WIDTH(CW)) u_reset_extension_count (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_load(ext_load),
    .i_load_value(reset_width_reg),
    .i_enable(state_reg == domain_reset_pkg::SEQ_EXTEND),
    .o_count(ext_count),
    .o_zero(ext_zero)
  );

  delay_down_counter #(.WIDTH(CW)) u_core_release_counter (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_load(core_load),
    .i_load_value(release_length_reg),
    .i_enable(state_reg == domain_reset_pkg::SEQ_RELEASE),
    .o_count(core_count),
    .o_zero(core_zero)
  );

  // ready delay counter waits for release
  delay_down_counter #(.WIDTH(CW)) u_ready_delay_counter (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_load(ready_load),
    .i_load_value(release_length_reg),
    .i_enable(state_reg == domain_reset_pkg::SEQ_READY_WAIT),
    .o_count(ready_count),
    .o_zero(ready_zero)
  );

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_DOMAIN_RESET_N <= 1'b0;
    end else if (start) begin
      O_DOMAIN_RESET_N <= 1'b0;
    end else if (ready_load) begin
      O_DOMAIN_RESET_N <= 1'b1;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_DOMAIN_READY <= 1'b0;
    end else if (start) begin
      O_DOMAIN_READY <= 1'b0;
    end else if ((state_reg == domain_reset_pkg::SEQ_READY_WAIT) && ready_zero) begin
      O_DOMAIN_READY <= 1'b1;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  // Helper: cycles spent in the current state and the value loaded on entry.
  logic [CW:0] span_reg;
  logic [CW-1:0] seg_len_reg;

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      span_reg <= '0;
      seg_len_reg <= '0;
    end else begin
      span_reg <= (state_next != state_reg) ? (CW+1)'(1) : span_reg + (CW+1)'(1);
      if (ext_load) begin
        seg_len_reg <= reset_width_reg;
      end else if (core_load || ready_load) begin
        seg_len_reg <= release_length_reg;
      end
    end
  end

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  sequence s_extend_done;
    (state_reg == domain_reset_pkg::SEQ_EXTEND) && ext_zero && !start;
  endsequence

  sequence s_release_done;
    (state_reg == domain_reset_pkg::SEQ_RELEASE) && core_zero && !start;
  endsequence

  sequence s_ready_done;
    (state_reg == domain_reset_pkg::SEQ_READY_WAIT) && ready_zero && !start;
  endsequence

  a_hold_keeps_reset: assert property (
    (state_reg == domain_reset_pkg::SEQ_HOLD) && !ack_sync_reg && !start |=>
      (state_reg == domain_reset_pkg::SEQ_HOLD) && !O_DOMAIN_RESET_N)
    else $error("Hold state left or reset released without acknowledge.");

  a_extend_load_width: assert property (
    (state_reg == domain_reset_pkg::SEQ_HOLD) && ack_sync_reg && !start |=>
      (state_reg == domain_reset_pkg::SEQ_EXTEND) && (ext_count == $past(reset_width_reg)))
    else $error("Extension counter not loaded from reset-width field.");

  a_extend_span_cycles: assert property (
    s_extend_done |-> (span_reg == {1'b0, seg_len_reg} + (CW+1)'(1)))
    else $error("Reset extension did not last value plus one cycles.");

  a_release_load_length: assert property (
    s_extend_done |=> (state_reg == domain_reset_pkg::SEQ_RELEASE) &&
      (core_count == $past(release_length_reg)) && !O_DOMAIN_RESET_N)
    else $error("Core release counter not loaded after extension.");

  a_release_span_cycles: assert property (
    s_release_done |-> (span_reg == {1'b0, seg_len_reg} + (CW+1)'(1)))
    else $error("Core release delay did not last value plus one cycles.");

  a_reset_released_zero: assert property (
    s_release_done |=> $rose(O_DOMAIN_RESET_N) && !O_DOMAIN_READY)
    else $error("Domain reset not released when core release count ended.");

  a_ready_waits_release: assert property (
    (state_reg == domain_reset_pkg::SEQ_READY_WAIT) |-> core_zero && O_DOMAIN_RESET_N &&
      (span_reg <= {1'b0, seg_len_reg} + (CW+1)'(1)))
    else $error("Ready delay counted before core release finished.");

  a_ready_raised_zero: assert property (
    s_ready_done |=> $rose(O_DOMAIN_READY) ##1 O_DOMAIN_READY || start)
    else $error("Domain ready not raised when ready delay ended.");

  a_count_ignores_write: assert property (
    (state_reg == domain_reset_pkg::SEQ_EXTEND) && !ext_zero && !start |=>
      (ext_count == $past(ext_count) - CW'(1)))
    else $error("Running extension count disturbed by register write.");

endmodule : domain_reset_release

// ==== rtl/domain_reset_pkg.sv ====
// Constants, types and register map for the domain reset-release sequencer.
// Assumes a single controller clock and a 32-bit APB register port.
package domain_reset_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int APB_ADDR_W = 12;
  localparam logic [11:0] RESET_WIDTH_OFFSET = 12'h018;
  localparam logic [11:0] RELEASE_LENGTH_OFFSET = 12'h038;
  localparam logic [11:0] SEQ_STATUS_OFFSET = 12'h040;
  localparam logic [11:0] SEQ_CONTROL_OFFSET = 12'h044;

  // ==========================================================================
  // Field layout and reset values
  // ==========================================================================
  localparam int COUNT_FIELD_LSB = 0;
  localparam int COUNT_FIELD_W = 10;
  localparam int CONTROL_START_BIT = 0;
  localparam logic [9:0] RESET_WIDTH_RESET = 10'h010;
  localparam logic [9:0] RELEASE_LENGTH_RESET = 10'h010;

  // ==========================================================================
  // Sequencer states and status word
  // ==========================================================================
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0,
    SEQ_HOLD = 3'h1,
    SEQ_EXTEND = 3'h2,
    SEQ_RELEASE = 3'h3,
    SEQ_READY_WAIT = 3'h4,
    SEQ_RUN = 3'h5
  } seq_state_t;

  typedef struct packed {
    logic [15:0] unused;
    logic ready;
    logic reset_n;
    logic hold_ack;
    logic [2:0] state;
    logic [9:0] count;
  } seq_status_t;

  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [3:0] strb;
    logic [31:0] wdata;
  } apb_req_t;

endpackage : domain_reset_pkg

// ==== rtl/delay_down_counter.sv ====
// Loadable down-counter that stops at zero.
// Assumes load and enable come from logic on the same clock.
`timescale 1ns/100ps
module delay_down_counter #(
  parameter int WIDTH = 10
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_load_value,
  input wire logic i_enable,
  output logic [WIDTH-1:0] o_count,
  output logic o_zero
);

  if (WIDTH < 1) begin : g_width_check
    $error("delay_down_counter needs WIDTH of at least 1");
  end

  // Load wins over counting so a fresh sequence never inherits a stale count.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_count <= '0;
    end else if (i_load) begin
      o_count <= i_load_value;
    end else if (i_enable && (o_count != '0)) begin
      o_count <= o_count - WIDTH'(1);
    end
  end

  assign o_zero = (o_count == '0);

endmodule : delay_down_counter

// ==== verification/domain_logic_model.sv ====
// Behavioural model of the logic inside the powered domain.
// Assumes it shares the controller clock and reset with the sequencer.
`timescale 1ns/100ps
module domain_logic_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_domain_reset_n,
  input wire logic i_domain_ready,
  input wire logic [7:0] i_ack_delay,
  output logic o_hold_ack
);
  logic [7:0] low_cnt;

  // ==========================================================================
  // Hold acknowledge
  // ==========================================================================
  // The domain answers a held reset only after a programmable settling time.
  // It withdraws the acknowledge once running, so every restart after ready waits afresh.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hold_ack <= 1'b0;
      low_cnt <= 8'h00;
    end else if (i_domain_ready) begin
      o_hold_ack <= 1'b0;
      low_cnt <= 8'h00;
    end else if (!i_domain_reset_n) begin
      if (low_cnt >= i_ack_delay) begin
        o_hold_ack <= 1'b1;
      end else begin
        low_cnt <= low_cnt + 8'h01;
      end
    end
  end
endmodule : domain_logic_model

// ==== verification/test_domain_reset_release.sv ====
// Self-checking bench for the domain reset-release sequencer.
// Assumes the domain model answers the held reset on its own.
`timescale 1ns/100ps
module test_domain_reset_release;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] pwdata = 32'h0;
  logic power_up = 1'b0;
  logic [7:0] ack_delay = 8'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hold_ack;
  logic domain_reset_n;
  logic domain_ready;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;

  always #2.5 sys_clk = ~sys_clk;

  domain_reset_release u_domain_reset_release (
    .I_SYS_CLK(sys_clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PSTRB(pstrb), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_POWER_UP(power_up), .I_RESET_HOLD_ACK(hold_ack),
    .O_DOMAIN_RESET_N(domain_reset_n), .O_DOMAIN_READY(domain_ready)
  );

  domain_logic_model u_domain_logic_model (
    .i_clk(sys_clk), .i_rst(rst), .i_domain_reset_n(domain_reset_n), .i_domain_ready(domain_ready),
    .i_ack_delay(ack_delay), .o_hold_ack(hold_ack)
  );

  // ==========================================================================
  // Checking and closing
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  // The longest sequence takes about 3100 cycles; the ceiling leaves wide margin.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 12000) begin
      err_count++;
      conclude();
    end
  end

  // ==========================================================================
  // Register access
  // ==========================================================================
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata, input logic [3:0] strb,
                     output logic [31:0] rdata, output logic err);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    pstrb <= strb;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(32'(n), 32'h1);
  endtask : apb

  task automatic wr(input logic [11:0] addr, input logic [31:0] data, input logic experr);
    logic [31:0] d;
    logic e;
    apb(1'b1, addr, data, 4'hf, d, e);
    check({31'h0, e}, {31'h0, experr});
  endtask : wr

  task automatic rd(input logic [11:0] addr, input logic [31:0] exp, input logic experr);
    logic [31:0] d;
    logic e;
    apb(1'b0, addr, 32'h0, 4'h0, d, e);
    check(d, exp);
    check({31'h0, e}, {31'h0, experr});
  endtask : rd

  // ==========================================================================
  // One power-up sequence with its timing measured at the pins
  // ==========================================================================
  // Release comes W+L+3 cycles after the start edge when the acknowledge is
  // already synchronised, otherwise W+L+5 after the acknowledge edge.
  task automatic run_seq(input int w, input int l, input logic via_reg);
    logic [31:0] d;
    logic e;
    logic ack0;
    int a;
    int tr;
    int ty;
    int n;
    if (via_reg) begin
      apb(1'b1, domain_reset_pkg::SEQ_CONTROL_OFFSET, 32'h1, 4'h1, d, e);
    end else begin
      @(posedge sys_clk);
      power_up <= 1'b1;
      @(posedge sys_clk);
      power_up <= 1'b0;
    end
    #1;
    ack0 = hold_ack;
    check({31'h0, domain_reset_n}, 32'h0);
    check({31'h0, domain_ready}, 32'h0);
    a = 0;
    tr = -1;
    ty = -1;
    n = 0;
    while (ty < 0 && n < 4000) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (a == 0 && !ack0 && hold_ack === 1'b1) a = n;
      if (tr < 0 && domain_reset_n === 1'b1) tr = n;
      if (tr < 0) check({31'h0, domain_ready}, 32'h0);
      if (domain_ready === 1'b1) ty = n;
    end
    check(32'(tr), 32'((ack0 ? 0 : a + 2) + w + l + 3));
    check(32'(ty - tr), 32'(l + 1));
  endtask : run_seq

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check({30'h0, domain_reset_n, domain_ready}, 32'h0);
    rd(domain_reset_pkg::RESET_WIDTH_OFFSET, 32'h010, 1'b0);
    rd(domain_reset_pkg::RELEASE_LENGTH_OFFSET, 32'h010, 1'b0);
    run_seq(16, 16, 1'b0);
    wr(domain_reset_pkg::RESET_WIDTH_OFFSET, 32'h0, 1'b0);
    wr(domain_reset_pkg::RELEASE_LENGTH_OFFSET, 32'h0, 1'b0);
    run_seq(0, 0, 1'b1);
    wr(domain_reset_pkg::RESET_WIDTH_OFFSET, 32'hffffffff, 1'b0);
    wr(domain_reset_pkg::RELEASE_LENGTH_OFFSET, 32'hffffffff, 1'b0);
    rd(domain_reset_pkg::RESET_WIDTH_OFFSET, 32'h3ff, 1'b0);
    rd(domain_reset_pkg::RELEASE_LENGTH_OFFSET, 32'h3ff, 1'b0);
    run_seq(1023, 1023, 1'b0);
    ack_delay <= 8'd40;
    wr(domain_reset_pkg::RESET_WIDTH_OFFSET, 32'h3, 1'b0);
    wr(domain_reset_pkg::RELEASE_LENGTH_OFFSET, 32'h7, 1'b0);
    run_seq(3, 7, 1'b0);
    wr(12'h100, 32'h5, 1'b1);
    rd(12'h100, 32'h0, 1'b1);
    wr(domain_reset_pkg::SEQ_STATUS_OFFSET, 32'h0, 1'b0);
    rd(domain_reset_pkg::SEQ_STATUS_OFFSET, 32'h0000_d400, 1'b0);
    rd(domain_reset_pkg::SEQ_CONTROL_OFFSET, 32'h0, 1'b0);
    ack_delay <= 8'd4;
    wr(domain_reset_pkg::RESET_WIDTH_OFFSET, 32'd200, 1'b0);
    wr(domain_reset_pkg::RELEASE_LENGTH_OFFSET, 32'h3, 1'b0);
    fork
      run_seq(200, 3, 1'b0);
      begin
        repeat (40) @(posedge sys_clk);
        wr(domain_reset_pkg::RESET_WIDTH_OFFSET, 32'h5, 1'b0);
      end
    join
    rd(domain_reset_pkg::RESET_WIDTH_OFFSET, 32'h5, 1'b0);
    run_seq(5, 3, 1'b0);
    begin : lane_write
      logic [31:0] d;
      logic e;
      // Only byte lane 0 is enabled, so bits 9:8 keep their old value of zero.
      apb(1'b1, domain_reset_pkg::RESET_WIDTH_OFFSET, 32'hffffffff, 4'h1, d, e);
    end
    rd(domain_reset_pkg::RESET_WIDTH_OFFSET, 32'h0ff, 1'b0);
    conclude();
  end
endmodule : test_domain_reset_release
